// [uart_holding_irq_enable.sv]
// One UART channel: holding registers, start-bit check, interrupt masks and line status.
//
// Summary of operation
// - Holding-register write with room queues the bus byte for the transmit shifter.
// - Holding-empty status is one when transmitter empty or byte passed to shifter.
// - Reading the receive holding register pops that byte from the receive queue.
// - Falling receive edge starts 16x count; mid-bit sample must still be low.
// - Mask bit 7 enables an interrupt on each clear-to-send low-to-high change.
// - Mask bit 6 enables an interrupt on each request-to-send low-to-high change.
// - Mask bit 5 gates the interrupt for a received Xoff character.
// - Mask bit 4 enables sleep mode; zero after reset disables it.
// - Mask bit 3 enables an interrupt when any modem-status change bit is set.
// - Mask bit 2 enables an interrupt while line-status error bits 1-4 show one.
// - Mask bit 1 enables the transmit-empty interrupt, holding or queue per mode.
// - Mask bit 0 enables receive interrupt: data held, or queue at trigger level.
// - In queue mode status shows trigger reached, clearing below trigger.
// - Data-ready bit 0 sets when a character enters the queue, clears when empty.
// - Queue-mode transmit-empty interrupt clears on status read or holding write.
// - Queues on with mask bits 0-3 and 5-7 clear means no interrupts; host polls.
// - Line-status bits 1-4 name overrun, parity, framing and break conditions.
// - Line-status bit 6 is one only when transmit queue and shifter are empty.
// - Line-status bit 7 is one while any queued received character has an error.
// - Enabled sources drive this channel's own interrupt output pin.
// - General registers are reachable only while line-control bit 7 is zero.
`timescale 1ns/10ps
module uart_holding_irq_enable
   import uart_hold_pkg::*;
#(
   parameter int         DEPTH      = FIFO_DEPTH,
   parameter int         SAMPLE_DIV = SAMPLE_DIV_CYCLES,
   parameter logic [7:0] XOFF_CHAR  = XOFF_CHAR_DEFAULT
) (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Host register bus.
   input  wire logic       bus_cs,
   input  wire logic [2:0] bus_addr,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   // Serial line and modem pins.
   input  wire logic       rx_line,
   output logic            tx_line,
   input  wire logic       cts_pin,
   output logic            rts_out,
   // Channel status.
   output logic            irq_out_chan_a,
   output logic            sleep_active
);

   localparam int AW = $clog2(DEPTH);
   localparam int RXW = DATA_BITS + 2;

   // Receive trigger level decode.
   function automatic logic [AW:0] trig_level(input logic [1:0] sel);
      case (sel)
         2'b00:   trig_level = (AW+1)'(TRIG_LEVEL_0);
         2'b01:   trig_level = (AW+1)'(TRIG_LEVEL_1);
         2'b10:   trig_level = (AW+1)'(TRIG_LEVEL_2);
         default: trig_level = (AW+1)'(TRIG_LEVEL_3);
      endcase
   endfunction

   // Control registers.
   logic [7:0] interrupt_mask;
   logic [7:0] fifo_control;
   logic [7:0] line_control;
   logic [7:0] modem_control;

   // Queue pointers and counts.
   logic [AW-1:0] tx_wr_ptr;
   logic [AW-1:0] tx_rd_ptr;
   logic [AW:0]   tx_cnt;
   logic [AW-1:0] rx_wr_ptr;
   logic [AW-1:0] rx_rd_ptr;
   logic [AW:0]   rx_cnt;
   logic [AW:0]   err_cnt;
   logic [7:0]    tx_head;
   logic [RXW-1:0] rx_head;

   // Sample tick and serial state.
   logic [15:0]  div_cnt;
   tx_state_type tx_state;
   logic [FRAME_BITS-1:0] tx_frame;
   logic [3:0]   tx_tick;
   logic [3:0]   tx_bits;
   rx_state_type rx_state;
   logic [3:0]   rx_tick;
   logic [3:0]   rx_bits;
   logic [7:0]   rx_shift;
   logic         rx_s1;
   logic         rx_s2;
   logic         rx_d;
   logic         cts_s1;
   logic         cts_s2;
   logic         cts_d;
   logic         rts_d;

   // Sticky flags.
   logic overrun;
   logic tx_evt;
   logic cts_rise;
   logic cts_delta;
   logic rts_rise;
   logic xoff_seen;

   // Bus decode.
   wire gen_ok      = ~line_control[LC_BANK];
   wire wr_cyc      = bus_cs & bus_wr;
   wire rd_cyc      = bus_cs & bus_rd;
   wire acc_ok      = gen_ok | (bus_addr == ADDR_LCTRL);
   wire wr_hold     = wr_cyc & gen_ok & (bus_addr == ADDR_HOLDING);
   wire wr_imask    = wr_cyc & gen_ok & (bus_addr == ADDR_IMASK);
   wire wr_fctrl    = wr_cyc & gen_ok & (bus_addr == ADDR_ISTAT);
   wire wr_lctrl    = wr_cyc & (bus_addr == ADDR_LCTRL);
   wire wr_mctrl    = wr_cyc & gen_ok & (bus_addr == ADDR_MCTRL);
   wire rd_hold     = rd_cyc & gen_ok & (bus_addr == ADDR_HOLDING);
   wire rd_istat    = rd_cyc & gen_ok & (bus_addr == ADDR_ISTAT);
   wire rd_lstat    = rd_cyc & gen_ok & (bus_addr == ADDR_LSTAT);
   wire rd_mstat    = rd_cyc & gen_ok & (bus_addr == ADDR_MSTAT);

   // Queue status; with queues off each queue holds a single byte.
   wire fifo_en     = fifo_control[FC_ENABLE];
   wire [AW:0] cap  = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
   wire tx_empty    = (tx_cnt == '0);
   wire tx_full     = (tx_cnt >= cap);
   wire rx_empty    = (rx_cnt == '0);
   wire rx_full     = (rx_cnt >= cap);
   wire tx_push     = wr_hold & ~tx_full;
   wire tx_pop      = (tx_state == TX_LOAD);
   wire rx_pop      = rd_hold & ~rx_empty;
   wire head_err    = rx_head[RXW-1] | rx_head[RXW-2];

   // Sample tick; the divider halts while asleep.
   wire tick        = ~sleep_active & (div_cnt == 16'(SAMPLE_DIV - 1));
   wire bit_end     = tick & (tx_tick == 4'(SAMPLES_PER_BIT - 1));
   wire rx_bit_end  = tick & (rx_tick == 4'(SAMPLES_PER_BIT - 1));
   wire rx_mid      = tick & (rx_tick == 4'(MID_SAMPLE));
   wire rx_fall     = rx_d & ~rx_s2;
   wire rx_done     = (rx_state == RX_STOP) & rx_bit_end;
   wire frame_err   = rx_done & ~rx_s2;
   wire brk         = frame_err & (rx_shift == 8'h00);
   wire rx_push     = rx_done & ~rx_full;
   wire rx_over     = rx_done & rx_full;
   wire xoff_evt    = rx_done & (rx_shift == XOFF_CHAR);
   wire [RXW-1:0] rx_entry = {brk, frame_err, rx_shift};

   // Status words.
   wire tx_idle     = (tx_state == TX_IDLE);
   wire [7:0] line_status = {
      err_cnt != '0,
      tx_empty & tx_idle,
      tx_empty,
      ~rx_empty & rx_head[RXW-1],
      ~rx_empty & rx_head[RXW-2],
      1'b0,
      overrun,
      ~rx_empty
   };
   wire [7:0] modem_status = {3'b000, cts_s2, 3'b000, cts_delta};
   wire rx_trig     = fifo_en & (rx_cnt >= trig_level(fifo_control[FC_TRIG_HI:FC_TRIG_LO]));
   wire rx_src      = fifo_en ? rx_trig : ~rx_empty;
   wire tx_src      = fifo_en ? tx_evt : tx_empty;
   wire line_src    = |line_status[4:1];
   wire modem_src   = |modem_status[3:0];

   // Each source is gated by its own mask bit; with bits 0-3 and 5-7 clear nothing fires.
   wire [7:0] sources = {cts_rise, rts_rise, xoff_seen, 1'b0, modem_src, line_src, tx_src, rx_src};
   wire next_irq    = |(sources & interrupt_mask);
   wire [7:0] interrupt_status = {fifo_en, fifo_en, 3'b000, rx_trig, tx_src, ~irq_out_chan_a};
   wire [7:0] next_rdata =
      ~acc_ok                    ? 8'h00 :
      (bus_addr == ADDR_HOLDING) ? rx_head[7:0] :
      (bus_addr == ADDR_IMASK)   ? interrupt_mask :
      (bus_addr == ADDR_ISTAT)   ? interrupt_status :
      (bus_addr == ADDR_LCTRL)   ? line_control :
      (bus_addr == ADDR_MCTRL)   ? modem_control :
      (bus_addr == ADDR_LSTAT)   ? line_status :
      (bus_addr == ADDR_MSTAT)   ? modem_status : 8'h00;
   wire next_sleep  = interrupt_mask[IM_SLEEP] & tx_idle & tx_empty &
                      (rx_state == RX_IDLE) & ~rx_fall & ~wr_hold;

   // Queue storage.
   uart_hold_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_mem (
      .clk     (mclk),
      .wr_en   (tx_push),
      .wr_addr (tx_wr_ptr),
      .wr_data (bus_wdata),
      .rd_addr (tx_rd_ptr),
      .rd_data (tx_head)
   );

   uart_hold_mem #(.WIDTH(RXW), .DEPTH(DEPTH), .AW(AW)) rx_mem (
      .clk     (mclk),
      .wr_en   (rx_push),
      .wr_addr (rx_wr_ptr),
      .wr_data (rx_entry),
      .rd_addr (rx_rd_ptr),
      .rd_data (rx_head)
   );

   // Host-written registers and bus read data.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         interrupt_mask <= IMASK_RST;
         fifo_control   <= FCTRL_RST;
         line_control   <= LCTRL_RST;
         modem_control  <= MCTRL_RST;
         bus_rdata      <= 8'h00;
      end else begin
         if (wr_imask) interrupt_mask <= bus_wdata;
         if (wr_fctrl) fifo_control <= bus_wdata;
         if (wr_lctrl) line_control <= bus_wdata;
         if (wr_mctrl) modem_control <= bus_wdata;
         if (rd_cyc) bus_rdata <= next_rdata;
      end
   end

   // Queue pointers and counts.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_wr_ptr <= '0;
         tx_rd_ptr <= '0;
         tx_cnt    <= '0;
         rx_wr_ptr <= '0;
         rx_rd_ptr <= '0;
         rx_cnt    <= '0;
         err_cnt   <= '0;
      end else begin
         if (tx_push) tx_wr_ptr <= tx_wr_ptr + AW'(1);
         if (tx_pop) tx_rd_ptr <= tx_rd_ptr + AW'(1);
         tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
         if (rx_push) rx_wr_ptr <= rx_wr_ptr + AW'(1);
         if (rx_pop) rx_rd_ptr <= rx_rd_ptr + AW'(1);
         rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
         err_cnt <= err_cnt + (AW+1)'(rx_push & frame_err) - (AW+1)'(rx_pop & head_err);
      end
   end

   // Sticky event flags; a set in the same cycle as its clear wins.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         overrun   <= 1'b0;
         tx_evt    <= 1'b0;
         cts_rise  <= 1'b0;
         cts_delta <= 1'b0;
         rts_rise  <= 1'b0;
         xoff_seen <= 1'b0;
      end else begin
         overrun   <= (overrun & ~rd_lstat) | rx_over;
         tx_evt    <= (tx_evt & ~rd_istat & ~wr_hold) | (tx_pop & (tx_cnt == (AW+1)'(1)) & ~tx_push);
         cts_rise  <= (cts_rise & ~rd_mstat) | (cts_s2 & ~cts_d);
         cts_delta <= (cts_delta & ~rd_mstat) | (cts_s2 ^ cts_d);
         rts_rise  <= (rts_rise & ~rd_istat) | (modem_control[MC_RTS] & ~rts_d);
         xoff_seen <= (xoff_seen & ~rd_istat) | xoff_evt;
      end
   end

   // Pin synchronisers, edge history and channel outputs.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_s1          <= 1'b1;
         rx_s2          <= 1'b1;
         rx_d           <= 1'b1;
         cts_s1         <= 1'b0;
         cts_s2         <= 1'b0;
         cts_d          <= 1'b0;
         rts_d          <= 1'b0;
         rts_out        <= 1'b0;
         irq_out_chan_a <= 1'b0;
         sleep_active   <= 1'b0;
         tx_line        <= 1'b1;
      end else begin
         rx_s1          <= rx_line;
         rx_s2          <= rx_s1;
         rx_d           <= rx_s2;
         cts_s1         <= cts_pin;
         cts_s2         <= cts_s1;
         cts_d          <= cts_s2;
         rts_d          <= modem_control[MC_RTS];
         rts_out        <= modem_control[MC_RTS];
         irq_out_chan_a <= next_irq;
         sleep_active   <= next_sleep;
         tx_line        <= tx_frame[0];
      end
   end

   // Sample-rate divider.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= 16'h0000;
      end else if (sleep_active || div_cnt == 16'(SAMPLE_DIV - 1)) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // Transmitter: the load state gives the queue's registered read one cycle to settle.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state <= TX_IDLE;
         tx_frame <= '1;
         tx_tick  <= 4'h0;
         tx_bits  <= 4'h0;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (!tx_empty) tx_state <= TX_LOAD;
            end
            TX_LOAD: begin
               tx_frame <= {1'b1, tx_head, 1'b0};
               tx_tick  <= 4'h0;
               tx_bits  <= 4'h0;
               tx_state <= TX_SHIFT;
            end
            TX_SHIFT: begin
               if (tick) tx_tick <= tx_tick + 4'h1;
               if (bit_end) begin
                  tx_frame <= {1'b1, tx_frame[FRAME_BITS-1:1]};
                  tx_bits  <= tx_bits + 4'h1;
                  if (tx_bits == 4'(FRAME_BITS - 1)) tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Receiver with false-start rejection at the middle of the start bit.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state <= RX_IDLE;
         rx_tick  <= 4'h0;
         rx_bits  <= 4'h0;
         rx_shift <= 8'h00;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               rx_tick <= 4'h0;
               if (rx_fall) rx_state <= RX_START;
            end
            RX_START: begin
               if (tick) rx_tick <= rx_tick + 4'h1;
               if (rx_mid) begin
                  rx_tick <= 4'h0;
                  rx_bits <= 4'h0;
                  if (rx_s2) begin
                     rx_state <= RX_IDLE;
                  end else begin
                     rx_state <= RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (tick) rx_tick <= rx_tick + 4'h1;
               if (rx_bit_end) begin
                  rx_shift <= {rx_s2, rx_shift[7:1]};
                  rx_bits  <= rx_bits + 4'h1;
                  if (rx_bits == 4'(DATA_BITS - 1)) rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (tick) rx_tick <= rx_tick + 4'h1;
               if (rx_bit_end) rx_state <= RX_IDLE;
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

endmodule // uart_holding_irq_enable

// [uart_hold_pkg.sv]
// Constants, register map and state types for the holding-register and interrupt-mask block.
package uart_hold_pkg;

   // Register offsets on the 3-bit host address.
   localparam logic [2:0] ADDR_HOLDING = 3'h0;
   localparam logic [2:0] ADDR_IMASK   = 3'h1;
   localparam logic [2:0] ADDR_ISTAT   = 3'h2;
   localparam logic [2:0] ADDR_LCTRL   = 3'h3;
   localparam logic [2:0] ADDR_MCTRL   = 3'h4;
   localparam logic [2:0] ADDR_LSTAT   = 3'h5;
   localparam logic [2:0] ADDR_MSTAT   = 3'h6;

   // Interrupt mask bit positions.
   localparam int IM_CTS   = 7;
   localparam int IM_RTS   = 6;
   localparam int IM_XOFF  = 5;
   localparam int IM_SLEEP = 4;
   localparam int IM_MODEM = 3;
   localparam int IM_LINE  = 2;
   localparam int IM_TX    = 1;
   localparam int IM_RX    = 0;

   // Other field positions.
   localparam int LC_BANK    = 7;
   localparam int FC_ENABLE  = 0;
   localparam int FC_TRIG_HI = 7;
   localparam int FC_TRIG_LO = 6;
   localparam int MC_RTS     = 1;

   // Values after reset.
   localparam logic [7:0] IMASK_RST = 8'h00;
   localparam logic [7:0] FCTRL_RST = 8'h00;
   localparam logic [7:0] LCTRL_RST = 8'h00;
   localparam logic [7:0] MCTRL_RST = 8'h00;

   // Receive trigger levels selected by the two trigger bits.
   localparam int TRIG_LEVEL_0 = 1;
   localparam int TRIG_LEVEL_1 = 4;
   localparam int TRIG_LEVEL_2 = 8;
   localparam int TRIG_LEVEL_3 = 14;

   // Framing and timing.
   localparam int FIFO_DEPTH        = 16;
   localparam int DATA_BITS         = 8;
   localparam int FRAME_BITS        = 10;
   localparam int SAMPLES_PER_BIT   = 16;
   localparam int MID_SAMPLE        = 7;
   localparam int CLK_PERIOD_NS     = 8;
   localparam int SAMPLE_PERIOD_NS  = 544;
   localparam int SAMPLE_DIV_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] XOFF_CHAR_DEFAULT = 8'h13;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_LOAD  = 3'b010,
      TX_SHIFT = 3'b100
   } tx_state_type;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_type;

endpackage

// [uart_hold_mem.sv]
// Small dual-port storage for the transmit and receive queues, with registered read data.
`timescale 1ns/10ps
module uart_hold_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock.
   input  wire logic             clk,
   // Write port.
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read port.
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] store [DEPTH];

   // No reset on the array keeps it mappable to plain RAM.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end

endmodule // uart_hold_mem

// [uart_hold_assertions.sv]
// Concurrent checks on the ports of the holding-register and interrupt-mask block.
`timescale 1ns/10ps
module uart_hold_checker
   import uart_hold_pkg::*;
(
   // Clock and reset.
   input wire logic       mclk,
   input wire logic       sys_rst,
   // Host bus.
   input wire logic       bus_cs,
   input wire logic [2:0] bus_addr,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   // Line, modem and status pins.
   input wire logic       rx_line,
   input wire logic       tx_line,
   input wire logic       cts_pin,
   input wire logic       rts_out,
   input wire logic       irq_out_chan_a,
   input wire logic       sleep_active
);
   logic [7:0] mask_q;
   logic [7:0] lctrl_q;
   logic       qon_q;
   wire        wr_on = bus_cs && bus_wr && !lctrl_q[LC_BANK];
   wire        rd_on = bus_cs && bus_rd && !lctrl_q[LC_BANK];
   // Shadow copies of the mask, line-control and queue-enable fields, so that reads and masks can be predicted.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_q  <= IMASK_RST;
         lctrl_q <= LCTRL_RST;
         qon_q   <= 1'b0;
      end else begin
         if (wr_on && bus_addr == ADDR_IMASK) mask_q <= bus_wdata;
         if (bus_cs && bus_wr && bus_addr == ADDR_LCTRL) lctrl_q <= bus_wdata;
         if (wr_on && bus_addr == ADDR_ISTAT) qon_q <= bus_wdata[FC_ENABLE];
      end
   end
   default clocking dck @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_mask_read_back: assert property (rd_on && bus_addr == ADDR_IMASK |=> bus_rdata == $past(mask_q))
      else $error("mask read back differs");
   a_bank_hides_regs: assert property (bus_cs && bus_rd && lctrl_q[LC_BANK] && bus_addr != ADDR_LCTRL |=> bus_rdata == 8'h00)
      else $error("general register seen in other bank");
   a_lctrl_read_back: assert property (bus_cs && bus_rd && bus_addr == ADDR_LCTRL |=> bus_rdata == $past(lctrl_q))
      else $error("line control read back differs");
   a_masked_quiet: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq_out_chan_a)
      else $error("interrupt with all masks clear");
   a_sleep_gated: assert property (sleep_active |-> mask_q[IM_SLEEP] || $past(mask_q[IM_SLEEP]))
      else $error("sleep without its mask bit");
   a_cts_rise_irq: assert property (mask_q[IM_CTS] && $rose(cts_pin) |-> ##[1:8] irq_out_chan_a)
      else $error("no interrupt on clear-to-send rise");
   a_rts_rise_irq: assert property (mask_q[IM_RTS] && $rose(rts_out) |-> ##[1:4] irq_out_chan_a)
      else $error("no interrupt on request-to-send rise");
   a_rx_irq_clear: assert property (rd_on && bus_addr == ADDR_HOLDING && mask_q == 8'h01 && !qon_q |-> ##[1:4] !irq_out_chan_a)
      else $error("receive interrupt stays after read");
   cover property ($fell(tx_line));
   cover property ($fell(rx_line));
   cover property ($rose(sleep_active));
endmodule // uart_hold_checker

bind uart_holding_irq_enable uart_hold_checker u_uart_hold_checker (.mclk(mclk), .sys_rst(sys_rst),
   .bus_cs(bus_cs), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata), .rx_line(rx_line), .tx_line(tx_line), .cts_pin(cts_pin), .rts_out(rts_out),
   .irq_out_chan_a(irq_out_chan_a), .sleep_active(sleep_active));

// [uart_line_model.sv]
// Serial line model on the far side of the receiver, sending 8N1 frames and noise pulses.
`timescale 1ns/10ps
module uart_line_model #(
   parameter int BIT_CYCLES = 32
) (
   // Clock.
   input  wire logic mclk,
   // Serial line toward the receiver.
   output logic      rx_line
);
   // The line idles high between frames, as a pulled-up line would.
   initial rx_line = 1'b1;
   task automatic send(input logic [7:0] data, input logic stop_bit);
      logic [9:0] frame;
      frame = {stop_bit, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk) rx_line <= frame[i];
         repeat (BIT_CYCLES - 1) @(posedge mclk);
      end
      @(posedge mclk) rx_line <= 1'b1;
      repeat (BIT_CYCLES) @(posedge mclk);
   endtask
   // A low pulse well short of half a bit imitates noise on an idle line.
   task automatic glitch(input int cycles);
      @(posedge mclk) rx_line <= 1'b0;
      repeat (cycles) @(posedge mclk);
      rx_line <= 1'b1;
      repeat (BIT_CYCLES * 12) @(posedge mclk);
   endtask
endmodule // uart_line_model

// [tb.sv]
// Self-checking bench: host register accesses against a serial line model.
`timescale 1ns/10ps
module tb;
   import uart_hold_pkg::*;
   localparam int SDIV = 2;
   localparam int BIT  = SAMPLES_PER_BIT * SDIV;
   logic       mclk      = 1'b0;
   logic       sys_rst   = 1'b1;
   logic       bus_cs    = 1'b0;
   logic [2:0] bus_addr  = 3'h0;
   logic       bus_wr    = 1'b0;
   logic       bus_rd    = 1'b0;
   logic [7:0] bus_wdata = 8'h00;
   logic       cts_pin   = 1'b0;
   logic [7:0] bus_rdata;
   logic       rx_line;
   logic       tx_line;
   logic       rts_out;
   logic       irq_out_chan_a;
   logic       sleep_active;
   logic [7:0] v;
   int         n_errors  = 0;
   int         compares  = 0;
   always #4 mclk = ~mclk;
   uart_holding_irq_enable #(.SAMPLE_DIV(SDIV)) u_uart_holding_irq_enable (.mclk(mclk), .sys_rst(sys_rst),
      .bus_cs(bus_cs), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .rx_line(rx_line), .tx_line(tx_line), .cts_pin(cts_pin), .rts_out(rts_out),
      .irq_out_chan_a(irq_out_chan_a), .sleep_active(sleep_active));
   uart_line_model #(.BIT_CYCLES(BIT)) u_uart_line_model (.mclk(mclk), .rx_line(rx_line));
   task automatic finish_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      {bus_cs, bus_wr, bus_addr, bus_wdata} <= {2'b11, a, d};
      @(posedge mclk);
      {bus_cs, bus_wr} <= 2'b00;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      {bus_cs, bus_rd, bus_addr} <= {2'b11, a};
      @(posedge mclk);
      {bus_cs, bus_rd} <= 2'b00;
      #1 d = bus_rdata;
   endtask
   task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(what, d, exp);
   endtask
   // Sampling on the falling edge keeps the result clear of the launching edge.
   task automatic wait_pin(input bit slp, input logic want);
      int i;
      logic s;
      for (i = 0; i < 2000; i++) begin
         @(negedge mclk);
         s = slp ? sleep_active : irq_out_chan_a;
         if (s === want) break;
      end
      chk(slp ? "sleep" : "irq", {7'h00, s}, {7'h00, want});
      if (i == 2000) finish_test();
   endtask
   task automatic tx_capture(input logic [7:0] exp);
      logic [7:0] got;
      for (int i = 0; i < 200 && tx_line !== 1'b0; i++) @(negedge mclk);
      chk("tx start", {7'h00, tx_line}, 8'h00);
      if (tx_line !== 1'b0) finish_test();
      repeat (BIT / 2) @(negedge mclk);
      for (int b = 0; b < 8; b++) begin
         repeat (BIT) @(negedge mclk);
         got[b] = tx_line;
      end
      chk("tx", got, exp);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      rchk("mask", ADDR_IMASK, IMASK_RST);
      rchk("lsr", ADDR_LSTAT, 8'h60);
      wr(ADDR_HOLDING, 8'ha5);
      tx_capture(8'ha5);
      rchk("lsr", ADDR_LSTAT, 8'h20);
      // The last data bit is still on the line here, with the stop bit to follow; wait past both before expecting an idle shifter.
      repeat (2 * BIT) @(posedge mclk);
      rchk("lsr", ADDR_LSTAT, 8'h60);
      wr(ADDR_IMASK, 8'h02);
      wait_pin(0, 1);
      wr(ADDR_IMASK, 8'h20);
      u_uart_line_model.send(XOFF_CHAR_DEFAULT, 1'b1);
      wait_pin(0, 1);
      rchk("lsr", ADDR_LSTAT, 8'h61);
      rd(ADDR_ISTAT, v);
      wait_pin(0, 0);
      wr(ADDR_IMASK, 8'h01);
      wait_pin(0, 1);
      rchk("rhr", ADDR_HOLDING, XOFF_CHAR_DEFAULT);
      wait_pin(0, 0);
      rchk("lsr", ADDR_LSTAT, 8'h60);
      u_uart_line_model.glitch(4 * SDIV);
      rchk("lsr", ADDR_LSTAT, 8'h60);
      wr(ADDR_IMASK, 8'h04);
      u_uart_line_model.send(8'h00, 1'b0);
      wait_pin(0, 1);
      rchk("lsr", ADDR_LSTAT, 8'hf9);
      rchk("rhr", ADDR_HOLDING, 8'h00);
      wait_pin(0, 0);
      wr(ADDR_IMASK, 8'h80);
      @(posedge mclk) cts_pin <= 1'b1;
      wait_pin(0, 1);
      rchk("msr", ADDR_MSTAT, 8'h11);
      wait_pin(0, 0);
      wr(ADDR_IMASK, 8'h08);
      @(posedge mclk) cts_pin <= 1'b0;
      wait_pin(0, 1);
      rchk("msr", ADDR_MSTAT, 8'h01);
      wait_pin(0, 0);
      wr(ADDR_IMASK, 8'h40);
      wr(ADDR_MCTRL, 8'h02);
      wait_pin(0, 1);
      chk("rts", {7'h00, rts_out}, 8'h01);
      rd(ADDR_ISTAT, v);
      wait_pin(0, 0);
      wr(ADDR_LCTRL, 8'h80);
      rchk("mask", ADDR_IMASK, 8'h00);
      wr(ADDR_IMASK, 8'hff);
      rchk("lcr", ADDR_LCTRL, 8'h80);
      wr(ADDR_LCTRL, 8'h00);
      rchk("mask", ADDR_IMASK, 8'h40);
      wr(ADDR_IMASK, 8'h10);
      wait_pin(1, 1);
      wr(ADDR_IMASK, 8'h00);
      wait_pin(1, 0);
      wr(ADDR_ISTAT, 8'h41);
      wr(ADDR_IMASK, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wait_pin(0, 0);
         u_uart_line_model.send(8'h30 + k[7:0], 1'b1);
      end
      wait_pin(0, 1);
      rd(ADDR_ISTAT, v);
      chk("isr", v & 8'hc5, 8'hc4);
      rchk("rhr", ADDR_HOLDING, 8'h30);
      wait_pin(0, 0);
      rd(ADDR_ISTAT, v);
      chk("isr", v & 8'h04, 8'h00);
      wr(ADDR_IMASK, 8'h00);
      wait_pin(0, 0);
      for (int k = 1; k < 4; k++) rchk("rhr", ADDR_HOLDING, 8'h30 + k[7:0]);
      rchk("lsr", ADDR_LSTAT, 8'h60);
      wr(ADDR_IMASK, 8'h02);
      rd(ADDR_ISTAT, v);
      wr(ADDR_HOLDING, 8'h5a);
      wait_pin(0, 1);
      wr(ADDR_HOLDING, 8'hc3);
      wait_pin(0, 0);
      wait_pin(0, 1);
      rd(ADDR_ISTAT, v);
      wait_pin(0, 0);
      finish_test();
   end
endmodule // tb
